// ---- src/rt_core_defines.vh ----
// constant-table core block: offsets, field positions, reset values, table constants
// assumes inclusion by bare name from the design file
`ifndef RT_CORE_DEFINES_VH
`define RT_CORE_DEFINES_VH

`define RTC_ADDR_W 13
`define RTC_OFF_BLK_INDEX 13'h0020
`define RTC_OFF_PTR_LO 13'h0028
`define RTC_OFF_PTR_HI 13'h002C
`define RTC_OFF_GPR_BASE 13'h0400
`define RTC_OFF_CTE_BASE 13'h0480
`define RTC_OFF_IMEM_BASE 13'h1000
`define RTC_PAGE_GPR 6'h08
`define RTC_PAGE_CTE 6'h09
`define RTC_IMEM_DEPTH 1024
`define RTC_IMEM_AW 10
`define RTC_RESET_WORD 32'h00000000

`define RTC_REG_OUTPUT 5'h1E
`define RTC_REG_STATUS 5'h1F
`define RTC_EV_VALID_BIT 5
`define RTC_BLK_A_LSB 0
`define RTC_BLK_B_LSB 16
`define RTC_BLK_FIELD_MASK 32'h000F000F
`define RTC_STATUS_W 30

`define RTC_TOP_ENTRY_A 8'h11
`define RTC_TOP_ENTRY_B 8'h40
`define RTC_TOP_ENTRY_C 8'h80
`define RTC_TOP_ENTRY_D 8'hC0
`define RTC_BLK_ENTRY_A_HI 20'h00000
`define RTC_BLK_ENTRY_B_HI 20'h01D00

`define RTC_CT_00 32'h00004000
`define RTC_CT_01 32'h01C20000
`define RTC_CT_02 32'h01C22000
`define RTC_CT_03 32'h00000000
`define RTC_CT_04 32'h00002000
`define RTC_CT_05 32'h01C40000
`define RTC_CT_06 32'h01C41000
`define RTC_CT_07 32'h01C42000
`define RTC_CT_08 32'h01D02000
`define RTC_CT_09 32'h01D06000
`define RTC_CT_10 32'h01D0A000
`define RTC_CT_11 32'h01D0C000
`define RTC_CT_12 32'h01D0D000
`define RTC_CT_13 32'h01E00000
`define RTC_CT_14 32'h01E25000
`define RTC_CT_15 32'h01E10000
`define RTC_CT_16 32'h01E12000
`define RTC_CT_17 32'h01E28000
`define RTC_CT_18 32'h01F00000
`define RTC_CT_19 32'h01F02000
`define RTC_CT_20 32'h01F04000
`define RTC_CT_21 32'h01F06000
`define RTC_CT_22 32'h01F07000
`define RTC_CT_23 32'h01F08000
`define RTC_CT_26 32'h01D04000
`define RTC_CT_27 32'h01D08000

`endif

// ---- src/rt_core_constant_table_io.v ----
// constant table, debug window, instruction memory, event strobes and special
// registers of one small real-time core, reached over an APB slave port
// assumes a single clock, a core that reports its run state on RUN_I and a
// partner core whose event pulses arrive on OTHER_EVENT_I
`timescale 1ns/1ps
`include "rt_core_defines.vh"

module rt_core_constant_table_io (
   input wire CLK_I,
   input wire RESET_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [12:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output reg PREADY_O,
   output reg PSLVERR_O,
   input wire RUN_I,
   input wire [9:0] PC_I,
   output reg [31:0] INSTR_O,
   input wire [4:0] CONST_IDX_I,
   output reg [31:0] CONST_BASE_O,
   input wire [4:0] CORE_RD_IDX_I,
   output reg [31:0] CORE_RD_DATA_O,
   input wire CORE_WR_EN_I,
   input wire [4:0] CORE_WR_IDX_I,
   input wire [31:0] CORE_WR_DATA_I,
   input wire [1:0] IRQ_IN_I,
   input wire [29:0] PRIMARY_STATUS_I,
   input wire [31:0] OTHER_EVENT_I,
   output reg [31:0] EVENT_PULSE_O,
   output reg [31:0] SYS_EVENT_O,
   output reg [31:0] GENERAL_OUTPUT_O,
   output reg OUTPUT_WRITE_STROBE_O
);

   reg [31:0] gpr [0:31];
   reg [31:0] imem [0:`RTC_IMEM_DEPTH-1];
   reg [31:0] blk_index;
   reg [31:0] ptr_lo;
   reg [31:0] ptr_hi;
   wire [31:0] const_entry [0:31];
   wire [31:0] status_word;
   wire [31:0] own_pulse;
   // word indices taken from the byte address
   wire [4:0] dbg_idx;
   wire [9:0] imem_idx;

   reg access;
   reg wr;
   reg sel_imem;
   reg sel_gpr;
   reg sel_cte;
   reg sel_blk;
   reg sel_ptr_lo;
   reg sel_ptr_hi;
   reg mapped;
   reg gpr_we;
   reg [4:0] gpr_widx;
   reg [31:0] gpr_wdata;
   reg [31:0] next_prdata;
   integer k;

   function [31:0] fixed_entry;
      input [4:0] idx;
      begin
         case (idx)
            5'h00: fixed_entry = `RTC_CT_00;
            5'h01: fixed_entry = `RTC_CT_01;
            5'h02: fixed_entry = `RTC_CT_02;
            5'h03: fixed_entry = `RTC_CT_03;
            5'h04: fixed_entry = `RTC_CT_04;
            5'h05: fixed_entry = `RTC_CT_05;
            5'h06: fixed_entry = `RTC_CT_06;
            5'h07: fixed_entry = `RTC_CT_07;
            5'h08: fixed_entry = `RTC_CT_08;
            5'h09: fixed_entry = `RTC_CT_09;
            5'h0A: fixed_entry = `RTC_CT_10;
            5'h0B: fixed_entry = `RTC_CT_11;
            5'h0C: fixed_entry = `RTC_CT_12;
            5'h0D: fixed_entry = `RTC_CT_13;
            5'h0E: fixed_entry = `RTC_CT_14;
            5'h0F: fixed_entry = `RTC_CT_15;
            5'h10: fixed_entry = `RTC_CT_16;
            5'h11: fixed_entry = `RTC_CT_17;
            5'h12: fixed_entry = `RTC_CT_18;
            5'h13: fixed_entry = `RTC_CT_19;
            5'h14: fixed_entry = `RTC_CT_20;
            5'h15: fixed_entry = `RTC_CT_21;
            5'h16: fixed_entry = `RTC_CT_22;
            5'h17: fixed_entry = `RTC_CT_23;
            5'h1A: fixed_entry = `RTC_CT_26;
            5'h1B: fixed_entry = `RTC_CT_27;
            default: fixed_entry = `RTC_RESET_WORD;
         endcase
      end
   endfunction

   // reserved entries are still driven; keeping away from them is up to software
   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : entry
         if (g == 24) begin : blk_a
            assign const_entry[g] = {`RTC_BLK_ENTRY_A_HI,
               blk_index[`RTC_BLK_A_LSB+3:`RTC_BLK_A_LSB], 8'h00};
         end else if (g == 25) begin : blk_b
            assign const_entry[g] = {`RTC_BLK_ENTRY_B_HI,
               blk_index[`RTC_BLK_B_LSB+3:`RTC_BLK_B_LSB], 8'h00};
         end else if (g == 28) begin : ptr_a
            assign const_entry[g] = {`RTC_TOP_ENTRY_A, ptr_lo[15:0], 8'h00};
         end else if (g == 29) begin : ptr_b
            assign const_entry[g] = {`RTC_TOP_ENTRY_B, ptr_lo[31:16], 8'h00};
         end else if (g == 30) begin : ptr_c
            assign const_entry[g] = {`RTC_TOP_ENTRY_C, ptr_hi[15:0], 8'h00};
         end else if (g == 31) begin : ptr_d
            assign const_entry[g] = {`RTC_TOP_ENTRY_D, ptr_hi[31:16], 8'h00};
         end else begin : fixed
            assign const_entry[g] = fixed_entry(g);
         end
         // one-hot demux of the event write
         assign own_pulse[g] = gpr_we && (gpr_widx == `RTC_REG_STATUS) &&
            gpr_wdata[`RTC_EV_VALID_BIT] && (gpr_wdata[4:0] == g);
      end
   endgenerate

   // register 31 has no storage: it shows the live inputs
   assign status_word = {IRQ_IN_I[1], IRQ_IN_I[0], PRIMARY_STATUS_I};
   assign dbg_idx = PADDR_I[6:2];
   assign imem_idx = PADDR_I[11:2];

   always @* begin
      access = PSEL_I && PENABLE_I && !PREADY_O;
      wr = access && PWRITE_I;
      sel_imem = PADDR_I[12];
      sel_gpr = !PADDR_I[12] && (PADDR_I[11:7] == `RTC_PAGE_GPR);
      sel_cte = !PADDR_I[12] && (PADDR_I[11:7] == `RTC_PAGE_CTE);
      sel_blk = (PADDR_I == `RTC_OFF_BLK_INDEX);
      sel_ptr_lo = (PADDR_I == `RTC_OFF_PTR_LO);
      sel_ptr_hi = (PADDR_I == `RTC_OFF_PTR_HI);
      mapped = (sel_imem || sel_gpr || sel_cte || sel_blk || sel_ptr_lo || sel_ptr_hi) &&
         (PADDR_I[1:0] == 2'b00);
   end

   // core owns the register file while running, the bus only while halted
   always @* begin
      if (RUN_I) begin
         gpr_we = CORE_WR_EN_I;
         gpr_widx = CORE_WR_IDX_I;
         gpr_wdata = CORE_WR_DATA_I;
      end else begin
         gpr_we = wr && sel_gpr && mapped;
         gpr_widx = dbg_idx;
         gpr_wdata = PWDATA_I;
      end
   end

   // read mux: locked regions answer zero while the core runs
   always @* begin
      next_prdata = `RTC_RESET_WORD;
      if (!mapped) begin
         next_prdata = `RTC_RESET_WORD;
      end else if (sel_blk) begin
         next_prdata = blk_index;
      end else if (sel_ptr_lo) begin
         next_prdata = ptr_lo;
      end else if (sel_ptr_hi) begin
         next_prdata = ptr_hi;
      end else if (RUN_I) begin
         next_prdata = `RTC_RESET_WORD;
      end else if (sel_imem) begin
         next_prdata = imem[PADDR_I[11:2]];
      end else if (sel_gpr) begin
         if (PADDR_I[6:2] == `RTC_REG_STATUS) begin
            next_prdata = status_word;
         end else begin
            next_prdata = gpr[PADDR_I[6:2]];
         end
      end else if (sel_cte) begin
         next_prdata = const_entry[PADDR_I[6:2]];
      end
   end

   // apb answer: pready one cycle into the access phase
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= access;
         PSLVERR_O <= access && !mapped;
      end
   end

   // read data stands only in the pready cycle, zero otherwise
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         PRDATA_O <= `RTC_RESET_WORD;
      end else if (access && !PWRITE_I) begin
         PRDATA_O <= next_prdata;
      end else begin
         PRDATA_O <= `RTC_RESET_WORD;
      end
   end

   // block index: only the two nibble fields are stored
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         blk_index <= `RTC_RESET_WORD;
      end else if (wr && mapped && sel_blk) begin
         blk_index <= PWDATA_I & `RTC_BLK_FIELD_MASK;
      end
   end

   // pointer pair for entries 28 and 29, reachable while running
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         ptr_lo <= `RTC_RESET_WORD;
      end else if (wr && mapped && sel_ptr_lo) begin
         ptr_lo <= PWDATA_I;
      end
   end

   // pointer pair for entries 30 and 31
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         ptr_hi <= `RTC_RESET_WORD;
      end else if (wr && mapped && sel_ptr_hi) begin
         ptr_hi <= PWDATA_I;
      end
   end

   // instruction memory: bus loads only while halted, word index = byte address / 4
   always @(posedge CLK_I) begin
      if (wr && mapped && sel_imem && !RUN_I) begin
         imem[imem_idx] <= PWDATA_I;
      end
   end

   always @(posedge CLK_I) begin
      if (RESET_I) begin
         for (k = 0; k < 32; k = k + 1) begin
            gpr[k] <= `RTC_RESET_WORD;
         end
      end else if (gpr_we && gpr_widx != `RTC_REG_STATUS) begin
         gpr[gpr_widx] <= gpr_wdata;
      end
   end

   // instruction fetch, one cycle after the word index
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         INSTR_O <= `RTC_RESET_WORD;
      end else begin
         INSTR_O <= imem[PC_I];
      end
   end

   // burst base from the table on its own port, no register file cycle
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         CONST_BASE_O <= `RTC_RESET_WORD;
      end else begin
         CONST_BASE_O <= const_entry[CONST_IDX_I];
      end
   end

   // core register read; register 31 shows the live status word
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         CORE_RD_DATA_O <= `RTC_RESET_WORD;
      end else begin
         if (CORE_RD_IDX_I == `RTC_REG_STATUS) begin
            CORE_RD_DATA_O <= status_word;
         end else begin
            CORE_RD_DATA_O <= gpr[CORE_RD_IDX_I];
         end
      end
   end

   // own event pulse, one cycle per register 31 write with bit 5 set
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         EVENT_PULSE_O <= `RTC_RESET_WORD;
      end else begin
         EVENT_PULSE_O <= own_pulse;
      end
   end

   // both cores' pulses merged channel by channel
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         SYS_EVENT_O <= `RTC_RESET_WORD;
      end else begin
         SYS_EVENT_O <= own_pulse | OTHER_EVENT_I;
      end
   end

   // output pins hold the last register 30 value
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         GENERAL_OUTPUT_O <= `RTC_RESET_WORD;
      end else if (gpr_we && gpr_widx == `RTC_REG_OUTPUT) begin
         GENERAL_OUTPUT_O <= gpr_wdata;
      end
   end

   // strobe for every register 30 write, debug writes included
   always @(posedge CLK_I) begin
      if (RESET_I) begin
         OUTPUT_WRITE_STROBE_O <= 1'b0;
      end else begin
         OUTPUT_WRITE_STROBE_O <= gpr_we && (gpr_widx == `RTC_REG_OUTPUT);
      end
   end

endmodule

// ---- bench/irq_ctrl_model.sv ----
// stand-in for the interrupt controller and the second core
// assumes requests from the bench on the block's clock
`timescale 1ns/1ps
module irq_ctrl_model (
   input wire clk_i,
   input wire fire_i,
   input wire [4:0] chan_i,
   input wire [1:0] level_i,
   output reg [31:0] event_o,
   output reg [1:0] irq_o
);
   always @(posedge clk_i) begin
      event_o <= fire_i ? (32'h00000001 << chan_i) : 32'h00000000;
      irq_o <= level_i;
   end
endmodule

// ---- bench/rt_core_constant_table_io_monitor.sv ----
// port assertions for the constant-table block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module rt_core_constant_table_io_monitor (
   input wire CLK_I,
   input wire RESET_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [31:0] PRDATA_O,
   input wire PREADY_O,
   input wire PSLVERR_O,
   input wire RUN_I,
   input wire [4:0] CORE_RD_IDX_I,
   input wire [31:0] CORE_RD_DATA_O,
   input wire CORE_WR_EN_I,
   input wire [4:0] CORE_WR_IDX_I,
   input wire [31:0] CORE_WR_DATA_I,
   input wire [1:0] IRQ_IN_I,
   input wire [29:0] PRIMARY_STATUS_I,
   input wire [31:0] OTHER_EVENT_I,
   input wire [31:0] EVENT_PULSE_O,
   input wire [31:0] SYS_EVENT_O,
   input wire [31:0] GENERAL_OUTPUT_O,
   input wire OUTPUT_WRITE_STROBE_O
);
   default clocking mcb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   AST_READY_WAIT: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
      else $error("ready late");
   AST_ERR_READY: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   AST_RDATA_IDLE: assert property (!(PREADY_O && !PWRITE_I) |-> PRDATA_O == 32'h0)
      else $error("read data not idle");
   AST_EVENT_ONEHOT: assert property ($onehot0(EVENT_PULSE_O))
      else $error("event not one-hot");
   AST_EVENT_CH: assert property (RUN_I && CORE_WR_EN_I && CORE_WR_IDX_I == 5'h1F |=>
      EVENT_PULSE_O == ($past(CORE_WR_DATA_I[5]) ? 32'h1 << $past(CORE_WR_DATA_I[4:0]) : 32'h0))
      else $error("event channel wrong");
   AST_SYS_OR: assert property (SYS_EVENT_O == (EVENT_PULSE_O | $past(OTHER_EVENT_I)))
      else $error("system event wrong");
   AST_OUT_REG: assert property (RUN_I && CORE_WR_EN_I && CORE_WR_IDX_I == 5'h1E |=>
      OUTPUT_WRITE_STROBE_O && GENERAL_OUTPUT_O == $past(CORE_WR_DATA_I))
      else $error("output register wrong");
   AST_STATUS_RD: assert property (CORE_RD_IDX_I == 5'h1F |=>
      CORE_RD_DATA_O == {$past(IRQ_IN_I), $past(PRIMARY_STATUS_I)})
      else $error("status word wrong");
endmodule

// ---- bench/rt_core_constant_table_io_bench.sv ----
// self-checking bench: APB host, core ports and the far-side model
// assumes the partner model and the monitor compile first
`timescale 1ns/1ps
module rt_core_constant_table_io_bench;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, run = 0, cwe = 0, fire = 0, err;
   logic [12:0] pa = 0;
   logic [31:0] pwd = 0, cwd = 0, rd, evs = 0, sevs = 0;
   logic [9:0] pc = 0;
   logic [4:0] cix = 0, cri = 0, cwi = 0, fch = 0;
   logic [29:0] stat = 30'h2AAAAAAA;
   logic [1:0] lvl = 2'h2;
   wire [31:0] prd, ins, cb, crd, oth, ev, sev, gpo;
   wire [1:0] irq;
   wire prdy, perr, stb;
   int error_cnt = 0, comparisons = 0, stbs = 0;
   rt_core_constant_table_io uut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .RUN_I(run), .PC_I(pc), .INSTR_O(ins), .CONST_IDX_I(cix),
      .CONST_BASE_O(cb), .CORE_RD_IDX_I(cri), .CORE_RD_DATA_O(crd), .CORE_WR_EN_I(cwe),
      .CORE_WR_IDX_I(cwi), .CORE_WR_DATA_I(cwd), .IRQ_IN_I(irq), .PRIMARY_STATUS_I(stat),
      .OTHER_EVENT_I(oth), .EVENT_PULSE_O(ev), .SYS_EVENT_O(sev), .GENERAL_OUTPUT_O(gpo),
      .OUTPUT_WRITE_STROBE_O(stb));
   irq_ctrl_model far (.clk_i(clk), .fire_i(fire), .chan_i(fch), .level_i(lvl),
      .event_o(oth), .irq_o(irq));
   initial forever #20 clk = ~clk;
   // pulses are accumulated so short strobes are not missed
   always @(posedge clk) begin
      if (!rst) begin
         evs <= evs | ev;
         sevs <= sevs | sev;
         stbs <= stbs + stb;
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 20);
      if (prdy !== 1'b1) begin
         error_cnt++;
         test_done;
      end
      rd = prd;
      err = perr;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [12:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(rd, e);
   endtask
   // core-side lookups: 0 general register, 1 constant port, 2 instruction fetch
   task automatic prt(input int k, input logic [9:0] i, input logic [31:0] e);
      if (k == 0) cri <= i[4:0];
      else if (k == 1) cix <= i[4:0];
      else pc <= i;
      repeat (2) @(posedge clk);
      chk(k == 0 ? crd : k == 1 ? cb : ins, e);
   endtask
   task automatic cw(input logic [4:0] i, input logic [31:0] d);
      cwe <= 1;
      cwi <= i;
      cwd <= d;
      @(posedge clk);
      cwe <= 0;
      @(posedge clk);
   endtask
   task automatic t_regs;
      rdc(13'h028, 32'h0);
      rdc(13'h02C, 32'h0);
      rdc(13'h020, 32'h0);
      apb(1, 13'h028, 32'hABCD1234);
      apb(1, 13'h02C, 32'h5678FEDC);
      apb(1, 13'h020, 32'hFFFFFFFF);
      apb(1, 13'h480, 32'hFFFFFFFF);
      rdc(13'h020, 32'h000F000F);
      rdc(13'h4E0, 32'h00000F00);
      rdc(13'h4E4, 32'h01D00F00);
      rdc(13'h4F0, 32'h11123400);
      rdc(13'h4F4, 32'h40ABCD00);
      rdc(13'h4F8, 32'h80FEDC00);
      rdc(13'h4FC, 32'hC0567800);
      rdc(13'h480, 32'h00004000);
      rdc(13'h4EC, 32'h01D08000);
      prt(1, 1, 32'h01C20000);
      prt(1, 29, 32'h40ABCD00);
      apb(1, 13'h000, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_debug;
      apb(1, 13'h414, 32'hCAFE0005);
      rdc(13'h414, 32'hCAFE0005);
      prt(0, 5, 32'hCAFE0005);
      apb(1, 13'h478, 32'h0000A5A5);
      chk(gpo, 32'h0000A5A5);
      chk(stbs, 32'h1);
      apb(1, 13'h47C, 32'h00000027);
      chk(evs, 32'h00000080);
      $display("t_debug done");
   endtask
   task automatic t_imem;
      apb(1, 13'h1020, 32'h89ABCDEF);
      apb(1, 13'h1FFC, 32'h0BADF00D);
      prt(2, 8, 32'h89ABCDEF);
      prt(2, 1023, 32'h0BADF00D);
      run <= 1;
      apb(1, 13'h1020, 32'h0);
      rdc(13'h1020, 32'h0);
      rdc(13'h414, 32'h0);
      run <= 0;
      rdc(13'h1020, 32'h89ABCDEF);
      $display("t_imem done");
   endtask
   task automatic t_run;
      run <= 1;
      cw(31, 32'h0000003F);
      chk(ev, 32'h80000000);
      chk(sev, 32'h80000000);
      cw(31, 32'h0000001F);
      chk(ev, 32'h0);
      cw(31, 32'h00000020);
      fire <= 1;
      fch <= 3;
      @(posedge clk);
      fire <= 0;
      repeat (3) @(posedge clk);
      chk(sevs, 32'h80000089);
      chk(evs, 32'h80000081);
      cw(30, 32'h12345678);
      chk(gpo, 32'h12345678);
      prt(0, 31, {lvl, stat});
      chk(stbs, 32'h2);
      run <= 0;
      $display("t_run done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_regs;
      t_debug;
      t_imem;
      t_run;
      test_done;
   end
endmodule
bind rt_core_constant_table_io rt_core_constant_table_io_monitor mon (.*);
